// ==== pkg/ppr_defs.vh ====
// Constants shared by the peripheral pin remap select block
//
// Summary of operation
// - Timer C channels follow its route select
// - Timer B channels follow its route select
// - Advanced timer A default pin set
// - Advanced timer A partial remap 01 moves break/complements, 10 the break only
// - Advanced timer A full remap onto port E; channel 4 and break unrouted
// - Advanced timer B trigger moves, channels 3-4 fixed
// - Advanced timer B channels 1-2 move on full
// - Advanced timer B break and complements follow select
// - CAN A pair over four pin pairs
// - CAN B pair over two pin pairs
// - Camera port fixed default pin set
// - Serial A transmit/receive move on select one
// - Serial B columns; select 10 lacks clock
// - Serial C transmit/receive/clock over three columns
`ifndef PPR_DEFS_VH
`define PPR_DEFS_VH

// Register byte offsets
`define PPR_REMAP_CFG_OFS    12'h000
`define PPR_REMAP_STAT_OFS   12'h004
`define PPR_REMAP_CFG_RESET  32'h00000000
`define PPR_REMAP_CFG_MASK   32'h000F7FFF

// Select field positions inside the remap configuration register
`define PPR_TMC_LSB          0
`define PPR_TMB_LSB          2
`define PPR_ADA_LSB          4
`define PPR_ADB_LSB          6
`define PPR_CANA_LSB         8
`define PPR_CANB_LSB         10
`define PPR_CAM_LSB          12
`define PPR_SERA_BIT         14
`define PPR_SERB_LSB         16
`define PPR_SERC_LSB         18
`define PPR_CFG_W            20

// AXI responses
`define PPR_RESP_OKAY        2'h0
`define PPR_RESP_SLVERR      2'h2

// Pin space: code = port * 16 + bit, ports A..E
`define PPR_GPIO_PINS        80
`define PPR_PIN_NONE         7'h7F
`define PPR_SIG_COUNT        54

// First peripheral signal index of each group
`define PPR_SIG_TMC          0
`define PPR_SIG_TMB          4
`define PPR_SIG_ADA          8
`define PPR_SIG_ADB          17
`define PPR_SIG_CANA         26
`define PPR_SIG_CANB         28
`define PPR_SIG_CAM          30
`define PPR_SIG_SERA         41
`define PPR_SIG_SERB         46
`define PPR_SIG_SERC         51

`endif

// ==== rtl/ppr_axil_regs.v ====
// AXI4-Lite slave holding the remap configuration and status registers
`timescale 1ns/1ns
`include "ppr_defs.vh"

module ppr_axil_regs #(
    parameter ADDR_W = 12
) (
    input  wire                  aclk,
    input  wire                  aresetn,
    input  wire [ADDR_W-1:0]     s_axil_awaddr,
    input  wire                  s_axil_awvalid,
    output reg                   s_axil_awready,
    input  wire [31:0]           s_axil_wdata,
    input  wire [3:0]            s_axil_wstrb,
    input  wire                  s_axil_wvalid,
    output reg                   s_axil_wready,
    output reg  [1:0]            s_axil_bresp,
    output reg                   s_axil_bvalid,
    input  wire                  s_axil_bready,
    input  wire [ADDR_W-1:0]     s_axil_araddr,
    input  wire                  s_axil_arvalid,
    output reg                   s_axil_arready,
    output reg  [31:0]           s_axil_rdata,
    output reg  [1:0]            s_axil_rresp,
    output reg                   s_axil_rvalid,
    input  wire                  s_axil_rready,
    input  wire [31:0]           status_word,
    output reg  [31:0]           remap_config_reg
);

    reg                  aw_got;
    reg                  w_got;
    reg  [ADDR_W-1:0]    aw_addr_q;
    reg  [31:0]          w_data_q;
    reg  [3:0]           w_strb_q;
    wire                 aw_take = s_axil_awvalid & s_axil_awready;
    wire                 w_take  = s_axil_wvalid & s_axil_wready;
    wire                 aw_have = aw_got | aw_take;
    wire                 w_have  = w_got | w_take;
    wire [ADDR_W-1:0]    wr_addr = aw_take ? s_axil_awaddr : aw_addr_q;
    wire [31:0]          wr_data = w_take ? s_axil_wdata : w_data_q;
    wire [3:0]           wr_strb = w_take ? s_axil_wstrb : w_strb_q;
    reg  [31:0]          merged;
    integer              i;

    // Byte lanes merged into the current value; unused bits stay zero
    always @* begin
        merged = remap_config_reg;
        for (i = 0; i < 4; i = i + 1) begin
            if (wr_strb[i]) begin
                merged[i*8 +: 8] = wr_data[i*8 +: 8];
            end
        end
        merged = merged & `PPR_REMAP_CFG_MASK;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data accepted in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_awready   <= 1'b0;
            s_axil_wready    <= 1'b0;
            s_axil_bvalid    <= 1'b0;
            s_axil_bresp     <= `PPR_RESP_OKAY;
            aw_got           <= 1'b0;
            w_got            <= 1'b0;
            aw_addr_q        <= {ADDR_W{1'b0}};
            w_data_q         <= 32'h00000000;
            w_strb_q         <= 4'h0;
            remap_config_reg <= `PPR_REMAP_CFG_RESET;
        end else if (s_axil_bvalid) begin
            if (s_axil_bready) begin
                s_axil_bvalid  <= 1'b0;
                s_axil_awready <= 1'b1;
                s_axil_wready  <= 1'b1;
            end
        end else if (aw_have && w_have) begin
            s_axil_bvalid  <= 1'b1;
            s_axil_awready <= 1'b0;
            s_axil_wready  <= 1'b0;
            aw_got         <= 1'b0;
            w_got          <= 1'b0;
            if (wr_addr[ADDR_W-1:2] == `PPR_REMAP_CFG_OFS >> 2) begin
                remap_config_reg <= merged;
                s_axil_bresp     <= `PPR_RESP_OKAY;
            end else if (wr_addr[ADDR_W-1:2] == `PPR_REMAP_STAT_OFS >> 2) begin
                // Status is read only; the write is dropped quietly
                s_axil_bresp     <= `PPR_RESP_OKAY;
            end else begin
                s_axil_bresp     <= `PPR_RESP_SLVERR;
            end
        end else begin
            aw_got         <= aw_have;
            w_got          <= w_have;
            s_axil_awready <= !aw_have;
            s_axil_wready  <= !w_have;
            if (aw_take) begin
                aw_addr_q <= s_axil_awaddr;
            end
            if (w_take) begin
                w_data_q <= s_axil_wdata;
                w_strb_q <= s_axil_wstrb;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_arready <= 1'b0;
            s_axil_rvalid  <= 1'b0;
            s_axil_rdata   <= 32'h00000000;
            s_axil_rresp   <= `PPR_RESP_OKAY;
        end else if (s_axil_rvalid) begin
            if (s_axil_rready) begin
                s_axil_rvalid  <= 1'b0;
                s_axil_arready <= 1'b1;
            end
        end else if (s_axil_arvalid && s_axil_arready) begin
            s_axil_rvalid  <= 1'b1;
            s_axil_arready <= 1'b0;
            if (s_axil_araddr[ADDR_W-1:2] == `PPR_REMAP_CFG_OFS >> 2) begin
                s_axil_rdata <= remap_config_reg;
                s_axil_rresp <= `PPR_RESP_OKAY;
            end else if (s_axil_araddr[ADDR_W-1:2] == `PPR_REMAP_STAT_OFS >> 2) begin
                s_axil_rdata <= status_word;
                s_axil_rresp <= `PPR_RESP_OKAY;
            end else begin
                s_axil_rdata <= 32'h00000000;
                s_axil_rresp <= `PPR_RESP_SLVERR;
            end
        end else begin
            s_axil_arready <= 1'b1;
        end
    end

endmodule // ppr_axil_regs

// ==== rtl/ppr_pin_remap.v ====
// Peripheral-to-pin remap routing with its AXI4-Lite configuration
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "ppr_defs.vh"

module ppr_pin_remap #(
    parameter ADDR_W = 12
) (
    input  wire                          aclk,
    input  wire                          aresetn,
    input  wire [ADDR_W-1:0]             s_axil_awaddr,
    input  wire                          s_axil_awvalid,
    output wire                          s_axil_awready,
    input  wire [31:0]                   s_axil_wdata,
    input  wire [3:0]                    s_axil_wstrb,
    input  wire                          s_axil_wvalid,
    output wire                          s_axil_wready,
    output wire [1:0]                    s_axil_bresp,
    output wire                          s_axil_bvalid,
    input  wire                          s_axil_bready,
    input  wire [ADDR_W-1:0]             s_axil_araddr,
    input  wire                          s_axil_arvalid,
    output wire                          s_axil_arready,
    output wire [31:0]                   s_axil_rdata,
    output wire [1:0]                    s_axil_rresp,
    output wire                          s_axil_rvalid,
    input  wire                          s_axil_rready,
    input  wire [`PPR_SIG_COUNT-1:0]     periph_out,
    input  wire [`PPR_SIG_COUNT-1:0]     periph_oe,
    output reg  [`PPR_SIG_COUNT-1:0]     periph_in,
    input  wire [`PPR_GPIO_PINS-1:0]     gpio_in,
    output reg  [`PPR_GPIO_PINS-1:0]     gpio_out,
    output reg  [`PPR_GPIO_PINS-1:0]     gpio_oe
);

    wire [31:0]                  remap_config_reg;
    reg  [`PPR_CFG_W-1:0]        eff_sel;
    reg  [`PPR_CFG_W-1:0]        next_eff_sel;
    wire [6:0]                   route [0:`PPR_SIG_COUNT-1];
    reg  [`PPR_GPIO_PINS-1:0]    next_gpio_out;
    reg  [`PPR_GPIO_PINS-1:0]    next_gpio_oe;
    reg  [`PPR_SIG_COUNT-1:0]    next_periph_in;
    integer                      s;

    ////////////////////////////////////////////////////////////////////////////
    // Register slave
    ppr_axil_regs #(
        .ADDR_W (ADDR_W)
    ) u_regs (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .s_axil_awaddr    (s_axil_awaddr),
        .s_axil_awvalid   (s_axil_awvalid),
        .s_axil_awready   (s_axil_awready),
        .s_axil_wdata     (s_axil_wdata),
        .s_axil_wstrb     (s_axil_wstrb),
        .s_axil_wvalid    (s_axil_wvalid),
        .s_axil_wready    (s_axil_wready),
        .s_axil_bresp     (s_axil_bresp),
        .s_axil_bvalid    (s_axil_bvalid),
        .s_axil_bready    (s_axil_bready),
        .s_axil_araddr    (s_axil_araddr),
        .s_axil_arvalid   (s_axil_arvalid),
        .s_axil_arready   (s_axil_arready),
        .s_axil_rdata     (s_axil_rdata),
        .s_axil_rresp     (s_axil_rresp),
        .s_axil_rvalid    (s_axil_rvalid),
        .s_axil_rready    (s_axil_rready),
        .status_word      ({12'h000, eff_sel}),
        .remap_config_reg (remap_config_reg)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Reserved codes collapse to no remap before any routing sees them
    function [1:0] keep_or_zero;
        input [1:0] sel;
        input [3:0] legal;
        begin
            keep_or_zero = legal[sel] ? sel : 2'h0;
        end
    endfunction

    always @* begin
        next_eff_sel = remap_config_reg[`PPR_CFG_W-1:0];
        next_eff_sel[`PPR_TMC_LSB +: 2] =
            keep_or_zero(remap_config_reg[`PPR_TMC_LSB +: 2], 4'hD);
        next_eff_sel[`PPR_ADB_LSB +: 2] =
            keep_or_zero(remap_config_reg[`PPR_ADB_LSB +: 2], 4'hB);
        next_eff_sel[`PPR_CANB_LSB +: 2] =
            keep_or_zero(remap_config_reg[`PPR_CANB_LSB +: 2], 4'h3);
        next_eff_sel[`PPR_CAM_LSB +: 2] =
            keep_or_zero(remap_config_reg[`PPR_CAM_LSB +: 2], 4'h1);
        next_eff_sel[`PPR_SERC_LSB +: 2] =
            keep_or_zero(remap_config_reg[`PPR_SERC_LSB +: 2], 4'hB);
        next_eff_sel[`PPR_SERA_BIT + 1] = 1'b0;
    end

    // The effective selects also feed the status register for software
    always @(posedge aclk) begin
        if (!aresetn) begin
            eff_sel <= {`PPR_CFG_W{1'b0}};
        end else begin
            eff_sel <= next_eff_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin table; codes are port * 16 + bit (A=0x0, B=0x1, C=0x2, D=0x3, E=0x4)
    function [6:0] pick4;
        input [1:0] sel;
        input [6:0] p0;
        input [6:0] p1;
        input [6:0] p2;
        input [6:0] p3;
        begin
            case (sel)
                2'h0:    pick4 = p0;
                2'h1:    pick4 = p1;
                2'h2:    pick4 = p2;
                default: pick4 = p3;
            endcase
        end
    endfunction

    function [6:0] pin_of;
        input [5:0]             sig;
        input [`PPR_CFG_W-1:0]  c;
        reg   [1:0]             tc;
        reg   [1:0]             tb;
        reg   [1:0]             aa;
        reg   [1:0]             ab;
        reg   [1:0]             ca;
        reg   [1:0]             sa;
        reg   [1:0]             sb;
        reg   [1:0]             sc;
        begin
            tc = c[`PPR_TMC_LSB +: 2];
            tb = c[`PPR_TMB_LSB +: 2];
            aa = c[`PPR_ADA_LSB +: 2];
            ab = c[`PPR_ADB_LSB +: 2];
            ca = c[`PPR_CANA_LSB +: 2];
            sa = {1'b0, c[`PPR_SERA_BIT]};
            sb = c[`PPR_SERB_LSB +: 2];
            sc = c[`PPR_SERC_LSB +: 2];
            case (sig)
                // Timer C channels 1-4
                6'd0:  pin_of = pick4(tc, 7'h06, 7'h06, 7'h14, 7'h26);
                6'd1:  pin_of = pick4(tc, 7'h07, 7'h07, 7'h15, 7'h27);
                6'd2:  pin_of = pick4(tc, 7'h10, 7'h10, `PPR_PIN_NONE, 7'h28);
                6'd3:  pin_of = pick4(tc, 7'h11, 7'h11, `PPR_PIN_NONE, 7'h29);
                // Timer B channels 1-4
                6'd4:  pin_of = pick4(tb, 7'h00, 7'h0F, 7'h00, 7'h0F);
                6'd5:  pin_of = pick4(tb, 7'h01, 7'h13, 7'h01, 7'h13);
                6'd6:  pin_of = pick4(tb, 7'h02, 7'h02, 7'h1A, 7'h1A);
                6'd7:  pin_of = pick4(tb, 7'h03, 7'h03, 7'h1B, 7'h1B);
                // Advanced timer A: trigger, channels 1-4, break, complements 1-3
                6'd8:  pin_of = pick4(aa, 7'h0C, 7'h0C, 7'h0C, 7'h47);
                6'd9:  pin_of = pick4(aa, 7'h08, 7'h08, 7'h08, 7'h49);
                6'd10: pin_of = pick4(aa, 7'h09, 7'h09, 7'h09, 7'h4B);
                6'd11: pin_of = pick4(aa, 7'h0A, 7'h0A, 7'h0A, 7'h4D);
                6'd12: pin_of = pick4(aa, 7'h0B, 7'h0B, 7'h0B, `PPR_PIN_NONE);
                6'd13: pin_of = pick4(aa, 7'h1C, 7'h06, 7'h15, `PPR_PIN_NONE);
                6'd14: pin_of = pick4(aa, 7'h1D, 7'h07, 7'h1D, 7'h48);
                6'd15: pin_of = pick4(aa, 7'h1E, 7'h10, 7'h1E, 7'h4A);
                6'd16: pin_of = pick4(aa, 7'h1F, 7'h11, 7'h1F, 7'h4C);
                // Advanced timer B: trigger, channels 1-4, break, complements 1-3
                6'd17: pin_of = pick4(ab, 7'h00, 7'h14, 7'h00, 7'h14);
                6'd18: pin_of = pick4(ab, 7'h26, 7'h26, 7'h26, 7'h3E);
                6'd19: pin_of = pick4(ab, 7'h27, 7'h27, 7'h27, 7'h3F);
                6'd20: pin_of = 7'h28;
                6'd21: pin_of = 7'h29;
                6'd22: pin_of = pick4(ab, 7'h06, 7'h13, 7'h06, 7'h13);
                6'd23: pin_of = pick4(ab, 7'h07, 7'h0F, 7'h07, 7'h0F);
                6'd24: pin_of = pick4(ab, 7'h10, 7'h2C, 7'h10, 7'h2C);
                6'd25: pin_of = pick4(ab, 7'h11, 7'h32, 7'h11, 7'h32);
                // CAN A receive, transmit
                6'd26: pin_of = pick4(ca, 7'h0B, 7'h38, 7'h18, 7'h30);
                6'd27: pin_of = pick4(ca, 7'h0C, 7'h39, 7'h19, 7'h31);
                // CAN B receive, transmit
                6'd28: pin_of = c[`PPR_CANB_LSB] ? 7'h15 : 7'h1C;
                6'd29: pin_of = c[`PPR_CANB_LSB] ? 7'h16 : 7'h1D;
                // Camera port: line sync, frame sync, pixel clock, data 0-7
                6'd30: pin_of = 7'h01;
                6'd31: pin_of = 7'h02;
                6'd32: pin_of = 7'h03;
                6'd33: pin_of = 7'h04;
                6'd34: pin_of = 7'h05;
                6'd35: pin_of = 7'h06;
                6'd36: pin_of = 7'h07;
                6'd37: pin_of = 7'h24;
                6'd38: pin_of = 7'h25;
                6'd39: pin_of = 7'h10;
                6'd40: pin_of = 7'h11;
                // Serial A: clear-to-send, request-to-send, transmit, receive, clock
                6'd41: pin_of = 7'h0B;
                6'd42: pin_of = 7'h0C;
                6'd43: pin_of = pick4(sa, 7'h09, 7'h16, 7'h09, 7'h09);
                6'd44: pin_of = pick4(sa, 7'h0A, 7'h17, 7'h0A, 7'h0A);
                6'd45: pin_of = 7'h08;
                // Serial B: clear-to-send, request-to-send, transmit, receive, clock
                6'd46: pin_of = pick4(sb, 7'h00, 7'h33, 7'h26, 7'h0F);
                6'd47: pin_of = pick4(sb, 7'h01, 7'h34, 7'h27, 7'h13);
                6'd48: pin_of = pick4(sb, 7'h02, 7'h35, 7'h28, 7'h14);
                6'd49: pin_of = pick4(sb, 7'h03, 7'h36, 7'h29, 7'h15);
                6'd50: pin_of = pick4(sb, 7'h04, 7'h37, `PPR_PIN_NONE, 7'h04);
                // Serial C: transmit, receive, clock
                6'd51: pin_of = pick4(sc, 7'h1A, 7'h2A, 7'h1A, 7'h38);
                6'd52: pin_of = pick4(sc, 7'h1B, 7'h2B, 7'h1B, 7'h39);
                6'd53: pin_of = pick4(sc, 7'h1C, 7'h2C, 7'h1C, 7'h3A);
                default: pin_of = `PPR_PIN_NONE;
            endcase
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < `PPR_SIG_COUNT; g = g + 1) begin : g_route
            assign route[g] = pin_of(g[5:0], eff_sel);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Crossbar; one pin code serves both directions of a signal
    // Shared pins (e.g. a camera data bit on a timer pin) are OR-ed: software
    // must not enable two drivers onto one pin.
    always @* begin
        next_gpio_out  = {`PPR_GPIO_PINS{1'b0}};
        next_gpio_oe   = {`PPR_GPIO_PINS{1'b0}};
        next_periph_in = {`PPR_SIG_COUNT{1'b0}};
        for (s = 0; s < `PPR_SIG_COUNT; s = s + 1) begin
            if (route[s] < `PPR_GPIO_PINS) begin
                next_gpio_out[route[s]] = next_gpio_out[route[s]]
                                          | (periph_out[s] & periph_oe[s]);
                next_gpio_oe[route[s]]  = next_gpio_oe[route[s]] | periph_oe[s];
                next_periph_in[s]       = gpio_in[route[s]];
            end
        end
    end

    // Registered outputs: one cycle of latency buys glitch-free pins
    always @(posedge aclk) begin
        if (!aresetn) begin
            gpio_out  <= {`PPR_GPIO_PINS{1'b0}};
            gpio_oe   <= {`PPR_GPIO_PINS{1'b0}};
            periph_in <= {`PPR_SIG_COUNT{1'b0}};
        end else begin
            gpio_out  <= next_gpio_out;
            gpio_oe   <= next_gpio_oe;
            periph_in <= next_periph_in;
        end
    end

endmodule // ppr_pin_remap

// ==== tb/ppr_pin_remap_asserts.sv ====
// Assertion checker for the pin remap block ports
`timescale 1ns/1ns
`include "ppr_defs.vh"
module ppr_pin_remap_asserts (
    input wire                        aclk,
    input wire                        aresetn,
    input wire                        s_axil_awvalid,
    input wire                        s_axil_awready,
    input wire                        s_axil_wvalid,
    input wire                        s_axil_wready,
    input wire                        s_axil_bvalid,
    input wire                        s_axil_bready,
    input wire [1:0]                  s_axil_bresp,
    input wire [`PPR_SIG_COUNT-1:0]   periph_oe,
    input wire [`PPR_SIG_COUNT-1:0]   periph_in,
    input wire [`PPR_GPIO_PINS-1:0]   gpio_in,
    input wire [`PPR_GPIO_PINS-1:0]   gpio_out,
    input wire [`PPR_GPIO_PINS-1:0]   gpio_oe
);
    default clocking cb @(posedge aclk); endclocking
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_wr_both;
        s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
    endsequence
    // Two settled edges, so the first sample after reset is not judged
    sequence s_run2;
        $past(aresetn) && $past(aresetn, 2);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    AST_RESET_QUIET: assert property (!aresetn |=> ~|gpio_oe && ~|periph_in)
        else $error("pins active after reset");
    AST_ADVB_FIXED_IN: assert property (disable iff (!aresetn) s_run2 |->
        periph_in[20] == $past(gpio_in[40]) && periph_in[21] == $past(gpio_in[41]))
        else $error("channel 3-4 sample not from fixed pins");
    AST_ADVB_FIXED_OUT: assert property (disable iff (!aresetn)
        s_run2 ##0 $past(periph_oe[20]) |-> gpio_oe[40])
        else $error("channel 3 drive missing on fixed pin");
    AST_CAM_IN: assert property (disable iff (!aresetn) s_run2 |->
        periph_in[30] == $past(gpio_in[1]) && periph_in[40] == $past(gpio_in[17]))
        else $error("camera sample not from default pins");
    AST_SERA_CLOCK: assert property (disable iff (!aresetn)
        s_run2 |-> periph_in[45] == $past(gpio_in[8]))
        else $error("serial clock sample not from fixed pin");
    AST_DRIVE_GATED: assert property (disable iff (!aresetn) ~|(gpio_out & ~gpio_oe))
        else $error("pin driven high without enable");
    AST_WR_ANSWER: assert property (disable iff (!aresetn)
        s_wr_both |=> s_axil_bvalid && !s_axil_awready && !s_axil_wready)
        else $error("write response late");
    AST_B_STANDS: assert property (disable iff (!aresetn)
        s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
        else $error("write response dropped");
endmodule // ppr_pin_remap_asserts

bind ppr_pin_remap ppr_pin_remap_asserts i_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
    .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
    .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
    .s_axil_bresp(s_axil_bresp), .periph_oe(periph_oe), .periph_in(periph_in),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe));

// ==== tb/ppr_far_side.sv ====
// Far-side model: peripheral drivers and pin levels
`timescale 1ns/1ns
`include "ppr_defs.vh"
module ppr_far_side (
    input  wire [`PPR_GPIO_PINS-1:0]  pattern,
    input  wire [5:0]                 drv_sig,
    output wire [`PPR_GPIO_PINS-1:0]  gpio_in,
    output wire [`PPR_SIG_COUNT-1:0]  periph_out,
    output wire [`PPR_SIG_COUNT-1:0]  periph_oe
);
    // One driver at a time, so a shared pin never hides a wrong route
    assign gpio_in    = pattern;
    assign periph_out = pattern[53:0] ^ pattern[79:26];
    assign periph_oe  = (drv_sig < 6'h36) ? (54'h1 << drv_sig) : 54'h0;
endmodule // ppr_far_side

// ==== tb/tb_peripheral_pin_remap_select.sv ====
// Self-checking bench for the pin remap block
`timescale 1ns/1ns
`include "ppr_defs.vh"
module tb_peripheral_pin_remap_select;
    reg          aclk = 1'b0, aresetn = 1'b0;
    reg  [11:0]  awaddr = 12'h000, araddr = 12'h000;
    reg  [31:0]  wdata = 32'h0;
    reg          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg  [79:0]  pattern = 80'h0;
    reg  [5:0]   drv_sig = 6'h3F;
    reg  [38:0]  tbl [0:12];
    integer      seed = 32'h83760C06, n_errors = 0, compares = 0;
    wire         awready, wready, bvalid, arready, rvalid;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [53:0]  periph_out, periph_oe, periph_in;
    wire [79:0]  gpio_in, gpio_out, gpio_oe;
    always #5 aclk = ~aclk;
    ppr_pin_remap #(.ADDR_W(12)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
        .s_axil_wdata(wdata), .s_axil_wstrb(4'hF), .s_axil_wvalid(wvalid),
        .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
        .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
        .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
        .s_axil_rvalid(rvalid), .s_axil_rready(rready), .periph_out(periph_out),
        .periph_oe(periph_oe), .periph_in(periph_in), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe));
    ppr_far_side i_far (.pattern(pattern), .drv_sig(drv_sig), .gpio_in(gpio_in),
        .periph_out(periph_out), .periph_oe(periph_oe));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input [79:0] seen, input [79:0] exp, input [8*16-1:0] what);
        compares = compares + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    task print_verdict;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Response ready is raised only after the answer shows, so it must stand
    task wr(input [11:0] a, input [31:0] d, output [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b1;
        end while (!(bvalid && bready));
        r = bresp;
        bready <= 1'b0;
    endtask
    task rd(input [11:0] a, output [31:0] d, output [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // Entry: signal, select lsb, pin for select 00, 01, 10, 11 (7F = none)
    task automatic probe(input integer k, input [31:0] cfg);
        reg [95:0] rnd;
        reg [6:0]  p;
        reg [5:0]  sg;
        reg [79:0] one;
        rnd = {$random(seed), $random(seed), $random(seed)};
        sg = tbl[k][38:33];
        p = tbl[k][7 * (3 - cfg[tbl[k][32:28] +: 2]) +: 7];
        one = (p == 7'h7F) ? 80'h0 : (80'h1 << p);
        @(posedge aclk);
        pattern <= rnd[79:0];
        drv_sig <= sg;
        repeat (4) @(posedge aclk);
        chk(gpio_oe, one, "pin enable");
        chk(gpio_out, one & {80{rnd[sg] ^ rnd[sg + 26]}}, "pin drive");
        chk({79'h0, periph_in[sg]}, {79'h0, |(rnd[79:0] & one)}, "pin sample");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin : main
        reg [31:0] d;
        reg [31:0] cfg;
        reg [1:0]  r;
        integer    k;
        integer    s;
        tbl[0]  = {6'h00, 5'h00, 7'h06, 7'h06, 7'h14, 7'h26};
        tbl[1]  = {6'h05, 5'h02, 7'h01, 7'h13, 7'h01, 7'h13};
        tbl[2]  = {6'h08, 5'h04, 7'h0C, 7'h0C, 7'h0C, 7'h47};
        tbl[3]  = {6'h0D, 5'h04, 7'h1C, 7'h06, 7'h15, 7'h7F};
        tbl[4]  = {6'h11, 5'h06, 7'h00, 7'h14, 7'h00, 7'h14};
        tbl[5]  = {6'h12, 5'h06, 7'h26, 7'h26, 7'h26, 7'h3E};
        tbl[6]  = {6'h16, 5'h06, 7'h06, 7'h13, 7'h06, 7'h13};
        tbl[7]  = {6'h1A, 5'h08, 7'h0B, 7'h38, 7'h18, 7'h30};
        tbl[8]  = {6'h1D, 5'h0A, 7'h1D, 7'h16, 7'h1D, 7'h1D};
        tbl[9]  = {6'h2B, 5'h0E, 7'h09, 7'h16, 7'h09, 7'h16};
        tbl[10] = {6'h32, 5'h10, 7'h04, 7'h37, 7'h7F, 7'h04};
        tbl[11] = {6'h33, 5'h12, 7'h1A, 7'h2A, 7'h1A, 7'h38};
        tbl[12] = {6'h14, 5'h06, 7'h28, 7'h28, 7'h28, 7'h28};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h000, d, r);
        chk({48'h0, d}, 80'h0, "config at reset");
        probe(3, 32'h0);
        rd(12'h100, d, r);
        chk({46'h0, r, d}, {46'h0, 2'h2, 32'h0}, "unmapped read");
        $display("test reset and map done");
        for (k = 0; k < 13; k = k + 1) begin
            for (s = 0; s < 4; s = s + 1) begin
                cfg = $random(seed);
                cfg[tbl[k][32:28] +: 2] = s[1:0];
                wr(12'h000, cfg, r);
                rd(12'h000, d, r);
                chk({48'h0, d}, {48'h0, cfg & 32'h000F7FFF}, "config readback");
                probe(k, cfg);
            end
        end
        wr(12'h000, 32'hFFFFFFFF, r);
        rd(12'h004, d, r);
        chk({46'h0, r, d}, {46'h0, 2'h0, 32'h000F43FF}, "status collapse");
        $display("test routing done");
        print_verdict;
    end
    initial begin
        #200000;
        n_errors = n_errors + 1;
        print_verdict;
    end
endmodule // tb_peripheral_pin_remap_select
